// ==== verilog/ppfs_pkg.sv ====
// Purpose: Shared constants and types for the port pin function select block.
// Assumes: Ports are numbered 0 to 22, eight pin positions each, one byte per register.
// Notes: Bit masks list the highest port first, so index [p] is port p.
package ppfs_pkg;

  // Port geometry
  localparam int NP = 23;
  localparam int PORT_W = 5;

  // Register offsets; the low five address bits select the port
  localparam logic [7:0] DATA_BASE = 8'h00;
  localparam logic [7:0] DIR_BASE = 8'h20;
  localparam logic [7:0] MODE_BASE = 8'h40;
  localparam logic [7:0] SEL_BASE = 8'h60;
  localparam logic [7:0] INCTL_ADDR = 8'h80;
  localparam logic [7:0] STATUS_ADDR = 8'h81;
  localparam logic [2:0] BASE_DATA = 3'h0;
  localparam logic [2:0] BASE_DIR = 3'h1;
  localparam logic [2:0] BASE_MODE = 3'h2;
  localparam logic [2:0] BASE_SEL = 3'h3;

  // Field positions
  localparam int INGATE_BIT = 0;
  localparam int SENSE_BREAK_BIT = 0;
  localparam int SENSE_STRAPA_BIT = 1;
  localparam int SENSE_STRAPB_BIT = 2;
  localparam int STRAP_A_IDX = 0;
  localparam int STRAP_B_IDX = 1;
  localparam int BREAK_IDX = 2;

  // Reset values
  localparam logic [7:0] RST_PORT_REG = 8'h00;
  localparam logic RST_INGATE = 1'b0;

  // Timing: edges after reset release before the mode straps are trusted
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'h5;

  // Implemented pin positions per port (port 22 first)
  localparam logic [NP-1:0][7:0] IMPL_MASK = {
    8'h23, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h09,
    8'h00, 8'hff, 8'hf0, 8'hff, 8'hff, 8'hf8, 8'hfc, 8'hff,
    8'h0e, 8'h00, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff};
  // Pins handed to the external bus in extension and processor modes
  localparam logic [NP-1:0][7:0] EXT_MASK = {
    8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff};
  // Triple-function pins, whose peripheral output is chosen by the select register
  localparam logic [NP-1:0][7:0] TRIPLE_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Input-only pin positions (never driven)
  localparam logic [NP-1:0][7:0] INONLY_MASK = {
    8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Dedicated sense positions: port 9, bits 0 to 2
  localparam logic [PORT_W-1:0] SENSE_PORT = 5'h09;
  localparam logic [7:0] SENSE_MASK = 8'h07;

  // CPU operation modes
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_EXT,
    MODE_PROC,
    MODE_RSVD
  } ppfs_mode_t;

  // Register kinds seen by the address decoder
  typedef enum logic [2:0] {
    REG_NONE,
    REG_DATA,
    REG_DIR,
    REG_MODE,
    REG_SEL,
    REG_INCTL,
    REG_STATUS
  } ppfs_reg_t;

endpackage

// ==== verilog/ppfs_sync.sv ====
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk.
// Notes: A change is accepted only once stages two and three agree.
`timescale 1ns/1ps
module ppfs_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Asynchronous in, filtered level out
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } ppfs_sync_state_t;

  ppfs_sync_state_t st;
  ppfs_sync_state_t next_st;
  logic [W-1:0] agree;

  // Stage one feeds only stage two, so metastability never reaches logic
  assign agree = ~(st.s2 ^ st.s3);

  // Shift chain and filtered level
  always_comb begin
    next_st = st;
    next_st.s1 = asyncIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.stable = (st.s2 & agree) | (st.stable & ~agree);
    if (sys_rst) begin
      next_st = '0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign syncOut = st.stable;

endmodule // ppfs_sync

// ==== verilog/ppfs_pin_mux.sv ====
// Purpose: Pin function multiplexer for the general-purpose ports.
// Assumes: One clock; pads, straps and break input are asynchronous pins.
// Notes: The CPU mode is captured once after reset and then held.
//   Every pad output and enable leaves a flip-flop, so owner changes show one cycle late.
//   Pad inputs pass the three-stage filter first, so a pad change takes four edges
//   to reach the gated input and one more to reach the peripherals or read data.
//   The reserved strap pair is reported as its own code but drives pins as single-chip,
//   which keeps an illegal board setting from handing pins to a bus that is not there.
//   The flash programming pin is not an input here: the frozen mode already makes
//   pin use independent of it and of the second strap.
//   Register bytes of unimplemented positions store zero and read back zero, except the port 9 sense positions of the data register.
//   Unmapped addresses and missing ports ignore writes and read zero.
//   Read data stand for one cycle only and are zero otherwise, so a bus that ORs
//   several slaves together needs no extra select logic.
// Overview of operation
// - Decode CPU mode from the two straps; both high is reserved.
// - Extension or processor mode hands ports 0-4 and pin 22.5 to the bus.
// - Other ports pick port or peripheral function per operation mode bit.
// - A peripheral with several functions chooses among them by its own select.
// - Flash pin and second strap levels during programming do not change pin use.
// - Triple-function pins drive only the peripheral output named by the select register.
// - Dedicated positions read back the break input and both strap levels.
// - Each implemented port has data, direction and mode registers; others none.
// - Each port pin is input or output by its direction bit.
// - Port input is blocked after reset until the input gate bit is set.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module ppfs_pin_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Mode straps and break input pins
  input wire logic modeStrapA,
  input wire logic modeStrapB,
  input wire logic systemBreakInputN,
  // Pads
  input wire logic [ppfs_pkg::NP-1:0][7:0] padIn,
  output logic [ppfs_pkg::NP-1:0][7:0] padOut,
  output logic [ppfs_pkg::NP-1:0][7:0] padOe,
  // Internal peripherals
  input wire logic [ppfs_pkg::NP-1:0][7:0] periphOutA,
  input wire logic [ppfs_pkg::NP-1:0][7:0] periphOeA,
  input wire logic [ppfs_pkg::NP-1:0][7:0] periphOutB,
  input wire logic [ppfs_pkg::NP-1:0][7:0] periphOeB,
  input wire logic [ppfs_pkg::NP-1:0][7:0] periphRoute,
  output logic [ppfs_pkg::NP-1:0][7:0] periphIn,
  // External extension bus
  input wire logic [ppfs_pkg::NP-1:0][7:0] busOut,
  input wire logic [ppfs_pkg::NP-1:0][7:0] busOe,
  output logic [ppfs_pkg::NP-1:0][7:0] busIn,
  // Mode status
  output logic [1:0] cpuModeOut,
  output logic modeValid
);
  import ppfs_pkg::*;

  typedef struct packed {
    logic [NP-1:0][7:0] portData;
    logic [NP-1:0][7:0] portDir;
    logic [NP-1:0][7:0] portMode;
    logic [NP-1:0][7:0] portSel;
    logic inputGate;
    ppfs_mode_t cpuMode;
    logic [2:0] settleCnt;
    logic modeValid;
    logic [7:0] rdData;
    logic [NP-1:0][7:0] padOut;
    logic [NP-1:0][7:0] padOe;
    logic [NP-1:0][7:0] periphIn;
    logic [NP-1:0][7:0] busIn;
  } ppfs_state_t;

  ppfs_state_t st;
  ppfs_state_t next_st;
  logic [NP-1:0][7:0] padSync;
  logic [NP-1:0][7:0] gatedIn;
  logic [2:0] pinSync;
  ppfs_reg_t regKind;
  logic [PORT_W-1:0] regPort;
  logic extActive;
  logic [7:0] senseByte;

  // Strap to mode decode; reserved is kept as its own code.
  // The decode runs once per reset, at capture time; it is a function so the
  // same mapping can be reused if a second capture point is ever added.
  // The code values equal the strap pair read as a two-bit number, first strap high.
  function automatic ppfs_mode_t decode_mode(input logic a, input logic b);
    ppfs_mode_t m;
    case ({a, b})
      2'b00: m = MODE_SINGLE;
      2'b01: m = MODE_EXT;
      2'b10: m = MODE_PROC;
      default: m = MODE_RSVD;
    endcase
    return m;
  endfunction

  // Address decode shared by the write and the read path.
  // Bits [7:5] pick the register kind and bits [4:0] the port.
  // A port with no implemented positions decodes as nothing at all, so its
  // writes vanish and its reads return zero without any per-port storage logic.
  // The two control addresses sit above the port banks and are matched exactly.
  function automatic ppfs_reg_t reg_kind(input logic [7:0] addr);
    ppfs_reg_t k;
    logic [PORT_W-1:0] p;
    k = REG_NONE;
    p = addr[PORT_W-1:0];
    if (addr == INCTL_ADDR) begin
      k = REG_INCTL;
    end else if (addr == STATUS_ADDR) begin
      k = REG_STATUS;
    end else if (addr[7] == 1'b0 && int'(p) < NP && IMPL_MASK[p] != 8'h00) begin
      case (addr[7:5])
        BASE_DATA: k = REG_DATA;
        BASE_DIR: k = REG_DIR;
        BASE_MODE: k = REG_MODE;
        BASE_SEL: k = REG_SEL;
        default: k = REG_NONE;
      endcase
    end
    return k;
  endfunction

  // Pads pass three flops before any logic sees them
  ppfs_sync #(
    .W(NP * 8)
  ) u_pad_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(padIn),
    .syncOut(padSync)
  );

  // Straps and break input share one synchroniser
  ppfs_sync #(
    .W(3)
  ) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn({systemBreakInputN, modeStrapB, modeStrapA}),
    .syncOut(pinSync)
  );

  // Decoded access and shared conditions
  assign regKind = reg_kind(regAddr);
  assign regPort = regAddr[PORT_W-1:0];
  assign extActive = st.cpuMode == MODE_EXT || st.cpuMode == MODE_PROC;
  assign gatedIn = st.inputGate ? padSync : '0;
  assign senseByte = {5'h00, pinSync[STRAP_B_IDX], pinSync[STRAP_A_IDX],
                      pinSync[BREAK_IDX]};

  // Next-state logic: registers, mode capture and the pin multiplexer
  always_comb begin
    next_st = st;

    // Register writes land only on implemented ports and positions
    if (regWrite) begin
      case (regKind)
        REG_DATA: next_st.portData[regPort] = regWdata & IMPL_MASK[regPort];
        REG_DIR: next_st.portDir[regPort] = regWdata & IMPL_MASK[regPort];
        REG_MODE: next_st.portMode[regPort] = regWdata & IMPL_MASK[regPort];
        REG_SEL: next_st.portSel[regPort] = regWdata & IMPL_MASK[regPort];
        REG_INCTL: next_st.inputGate = regWdata[INGATE_BIT];
        default: next_st.inputGate = st.inputGate;
      endcase
    end

    // Read data stands one cycle after the strobe, zero otherwise
    next_st.rdData = 8'h00;
    if (regRead) begin
      case (regKind)
        REG_DATA: begin
          // Outputs read back the latch, inputs the gated pin level
          next_st.rdData = ((st.portData[regPort] & st.portDir[regPort]) |
                            (gatedIn[regPort] & ~st.portDir[regPort])) &
                           IMPL_MASK[regPort];
          if (regPort == SENSE_PORT) begin
            next_st.rdData = (next_st.rdData & ~SENSE_MASK) | senseByte;
          end
        end
        REG_DIR: next_st.rdData = st.portDir[regPort];
        REG_MODE: next_st.rdData = st.portMode[regPort];
        REG_SEL: next_st.rdData = st.portSel[regPort];
        REG_INCTL: next_st.rdData = {7'h00, st.inputGate};
        REG_STATUS: next_st.rdData = {5'h00, st.modeValid, st.cpuMode};
        default: next_st.rdData = 8'h00;
      endcase
    end

    // Mode is taken once the straps have settled and then frozen, so later
    // strap or flash-pin activity during programming cannot move pin owners
    if (!st.modeValid) begin
      if (st.settleCnt == STRAP_SETTLE_CYC - 3'h1) begin
        next_st.cpuMode = decode_mode(pinSync[STRAP_A_IDX], pinSync[STRAP_B_IDX]);
        next_st.modeValid = 1'b1;
      end else begin
        next_st.settleCnt = st.settleCnt + 3'h1;
      end
    end

    // Per-pin owner selection.
    // Priority, highest first:
    //   1. Unimplemented, input-only and sense positions are never driven.
    //   2. Bus-group pins follow the captured CPU mode and ignore the mode register.
    //   3. Other pins with their mode bit set go to a peripheral function.
    //   4. Everything else is an ordinary port pin under data and direction.
    // Inputs to peripherals and the bus are gated the same way as port reads,
    // so nothing downstream sees floating pads before software opens the gate.
    // The choice is registered, trading one cycle of latency for clean outputs.
    for (int p = 0; p < NP; p++) begin
      for (int b = 0; b < 8; b++) begin
        next_st.periphIn[p][b] = gatedIn[p][b] & IMPL_MASK[p][b];
        next_st.busIn[p][b] = gatedIn[p][b] & EXT_MASK[p][b] & extActive;
        if (!IMPL_MASK[p][b] || INONLY_MASK[p][b] ||
            (p == int'(SENSE_PORT) && SENSE_MASK[b])) begin
          // Never driven; sense positions are inputs only
          next_st.padOut[p][b] = 1'b0;
          next_st.padOe[p][b] = 1'b0;
        end else if (EXT_MASK[p][b]) begin
          if (extActive) begin
            next_st.padOut[p][b] = busOut[p][b];
            next_st.padOe[p][b] = busOe[p][b];
          end else begin
            next_st.padOut[p][b] = st.portData[p][b];
            next_st.padOe[p][b] = st.portDir[p][b];
          end
        end else if (st.portMode[p][b]) begin
          // Triple pins obey the select register, others the peripheral's own choice
          if (TRIPLE_MASK[p][b] ? st.portSel[p][b] : periphRoute[p][b]) begin
            next_st.padOut[p][b] = periphOutB[p][b];
            next_st.padOe[p][b] = periphOeB[p][b];
          end else begin
            next_st.padOut[p][b] = periphOutA[p][b];
            next_st.padOe[p][b] = periphOeA[p][b];
          end
        end else begin
          next_st.padOut[p][b] = st.portData[p][b];
          next_st.padOe[p][b] = st.portDir[p][b];
        end
      end
    end

    // Synchronous reset: all ports inputs, input path blocked.
    // Reset comes last so it overrides every write, read and capture above.
    // The mode counter restarts, so straps are sampled afresh after every reset;
    // a board that changes its straps must therefore pass through a reset.
    if (sys_rst) begin
      next_st = '0;
      for (int p = 0; p < NP; p++) begin
        next_st.portData[p] = RST_PORT_REG;
        next_st.portDir[p] = RST_PORT_REG;
        next_st.portMode[p] = RST_PORT_REG;
        next_st.portSel[p] = RST_PORT_REG;
      end
      next_st.inputGate = RST_INGATE;
      next_st.cpuMode = MODE_SINGLE;
      next_st.settleCnt = 3'h0;
      next_st.modeValid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Outputs straight from the state register.
  // No output is formed by logic after the flip-flops, so pad timing does not
  // depend on the register bus or on peripheral paths.
  assign regRdata = st.rdData;
  assign padOut = st.padOut;
  assign padOe = st.padOe;
  assign periphIn = st.periphIn;
  assign busIn = st.busIn;
  assign cpuModeOut = st.cpuMode;
  assign modeValid = st.modeValid;

endmodule // ppfs_pin_mux

// ==== tb/ppfs_far_model.sv ====
// Purpose: Behavioural peripherals and external bus facing the pin mux.
// Assumes: Same clock as the mux; the bench picks the patterns.
// Notes: Every port sees one pattern, which keeps expectations short.
`timescale 1ns/1ps
module ppfs_far_model (
  // Clock
  input wire logic clk,
  // Patterns from the bench
  input wire logic [7:0] valA,
  input wire logic [7:0] valB,
  input wire logic [7:0] route,
  input wire logic [7:0] busVal,
  // Toward the mux
  output logic [ppfs_pkg::NP-1:0][7:0] periphOutA,
  output logic [ppfs_pkg::NP-1:0][7:0] periphOeA,
  output logic [ppfs_pkg::NP-1:0][7:0] periphOutB,
  output logic [ppfs_pkg::NP-1:0][7:0] periphOeB,
  output logic [ppfs_pkg::NP-1:0][7:0] periphRoute,
  output logic [ppfs_pkg::NP-1:0][7:0] busOut,
  output logic [ppfs_pkg::NP-1:0][7:0] busOe
);
  import ppfs_pkg::*;
  // Launched from clk like real peripherals; enables always on to expose routing
  always_ff @(posedge clk) begin
    for (int p = 0; p < NP; p++) begin
      periphOutA[p] <= valA;
      periphOeA[p] <= 8'hff;
      periphOutB[p] <= valB;
      periphOeB[p] <= 8'hff;
      periphRoute[p] <= route;
      busOut[p] <= busVal;
      busOe[p] <= 8'hff;
    end
  end
endmodule // ppfs_far_model

// ==== tb/ppfs_pin_mux_sva.sv ====
// Purpose: Port-level checks for the pin function multiplexer.
// Assumes: Straps steady from reset release until the mode is captured.
// Notes: Only port 0 of the bus group is watched, to keep this small.
`timescale 1ns/1ps
module ppfs_pin_mux_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // Straps and mode
  input wire logic modeStrapA,
  input wire logic modeStrapB,
  input wire logic [1:0] cpuModeOut,
  input wire logic modeValid,
  // Pads and bus
  input wire logic [ppfs_pkg::NP-1:0][7:0] padOe,
  input wire logic [ppfs_pkg::NP-1:0][7:0] padOut,
  input wire logic [ppfs_pkg::NP-1:0][7:0] busOut,
  input wire logic [ppfs_pkg::NP-1:0][7:0] busOe,
  input wire logic [ppfs_pkg::NP-1:0][7:0] busIn
);
  import ppfs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Mode capture: five quiet edges, then valid
  sequence s_settle; !modeValid [*5]; endsequence
  sequence s_valid; modeValid; endsequence
  property p_capture; $fell(sys_rst) |-> s_settle ##1 s_valid; endproperty
  a_capture: assert property (p_capture) else $error("mode capture late or early");
  property p_decode; $rose(modeValid) |-> cpuModeOut == {$past(modeStrapA), $past(modeStrapB)};
  endproperty
  a_decode: assert property (p_decode) else $error("mode decode wrong");
  // Once captured, strap changes must not move the mode
  property p_frozen; modeValid |=> modeValid && $stable(cpuModeOut); endproperty
  a_frozen: assert property (p_frozen) else $error("mode not frozen");
  property p_status; regRead && regAddr == STATUS_ADDR |=>
    regRdata == {5'h00, $past(modeValid), $past(cpuModeOut)}; endproperty
  a_status: assert property (p_status) else $error("status read wrong");
  property p_idle; !$past(regRead) |-> regRdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
  // Bus owns port 0 in extension and processor modes
  property p_bus; modeValid && cpuModeOut inside {MODE_EXT, MODE_PROC} |=>
    padOut[0] == $past(busOut[0]) && padOe[0] == $past(busOe[0]); endproperty
  a_bus: assert property (p_bus) else $error("bus pins not handed over");
  property p_nobus; modeValid && cpuModeOut inside {MODE_SINGLE, MODE_RSVD} |=> busIn[0] == 8'h00;
  endproperty
  a_nobus: assert property (p_nobus) else $error("bus input leaks in single-chip");
  property p_undriven; padOe[5] == 8'h00 && padOe[9][2:0] == 3'h0 && !padOe[22][1];
  endproperty
  a_undriven: assert property (p_undriven) else $error("dedicated pin driven");
endmodule // ppfs_pin_mux_sva
bind ppfs_pin_mux ppfs_pin_mux_sva u_sva (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regRead(regRead), .regRdata(regRdata), .modeStrapA(modeStrapA), .modeStrapB(modeStrapB),
  .cpuModeOut(cpuModeOut), .modeValid(modeValid), .padOe(padOe), .padOut(padOut),
  .busOut(busOut), .busOe(busOe), .busIn(busIn));

// ==== tb/test_port_pin_function_select.sv ====
// Purpose: Self-checking bench for the pin function multiplexer.
// Assumes: Mode only changes across a reset, so each strap row resets.
// Notes: Peripheral A=11, B=22, route 0f; bus pattern 3c.
`timescale 1ns/1ps
module test_port_pin_function_select;
  import ppfs_pkg::*;
  typedef struct packed {logic a; logic b; logic [7:0] stat; logic [7:0] pad0;} ppfs_row_t;
  logic clk, sys_rst, regWrite, regRead, modeStrapA, modeStrapB, systemBreakInputN, modeValid;
  logic [7:0] regAddr, regWdata, regRdata, valA, valB, route, busVal, d;
  logic [1:0] cpuModeOut;
  logic [NP-1:0][7:0] padIn, padOut, padOe, periphOutA, periphOeA, periphOutB, periphOeB;
  logic [NP-1:0][7:0] periphRoute, periphIn, busOut, busOe, busIn;
  int miscompares, nChecks, cycles;
  ppfs_row_t rows[4] = '{'{1'b0, 1'b1, 8'h05, 8'h3c}, '{1'b1, 1'b0, 8'h06, 8'h3c},
    '{1'b1, 1'b1, 8'h07, 8'ha5}, '{1'b0, 1'b0, 8'h04, 8'ha5}};
  ppfs_pin_mux DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .modeStrapA(modeStrapA),
    .modeStrapB(modeStrapB), .systemBreakInputN(systemBreakInputN), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .periphOutA(periphOutA), .periphOeA(periphOeA),
    .periphOutB(periphOutB), .periphOeB(periphOeB), .periphRoute(periphRoute),
    .periphIn(periphIn), .busOut(busOut), .busOe(busOe), .busIn(busIn),
    .cpuModeOut(cpuModeOut), .modeValid(modeValid));
  ppfs_far_model u_far (.clk(clk), .valA(valA), .valB(valB), .route(route), .busVal(busVal),
    .periphOutA(periphOutA), .periphOeA(periphOeA), .periphOutB(periphOutB),
    .periphOeB(periphOeB), .periphRoute(periphRoute), .busOut(busOut), .busOe(busOe));
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard; the full run needs about 135 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1500) begin
      miscompares++;
      report_and_stop();
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {sys_rst, regWrite, regRead, modeStrapA, modeStrapB, regAddr, regWdata} = '0;
    sys_rst = 1'b1;
    systemBreakInputN = 1'b1;
    {miscompares, nChecks, cycles} = '0;
    {valA, valB, route, busVal} = {8'h11, 8'h22, 8'h0f, 8'h3c};
    padIn = '0;
    padIn[10] = 8'h5a;
    // One reset per strap combination; port 0 owner follows the mode
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sys_rst <= 1'b1;
      modeStrapA <= rows[i].a;
      modeStrapB <= rows[i].b;
      cyc(5);
      sys_rst <= 1'b0;
      cyc(7);
      rd(STATUS_ADDR, d);
      chk(d, rows[i].stat);
      wr(DATA_BASE, 8'ha5);
      wr(DIR_BASE, 8'hff);
      cyc(2);
      #1 chk(padOut[0], rows[i].pad0);
      chk(padOe[0], 8'hff);
      $display("strap row %0d done", i);
    end
    // Peripheral ownership on port 10, then half back to port function
    wr(MODE_BASE + 8'h0a, 8'hff);
    cyc(2);
    #1 chk(padOut[10], 8'h12);
    wr(MODE_BASE + 8'h0a, 8'hf0);
    cyc(2);
    #1 chk(padOut[10], 8'h10);
    chk(padOe[10], 8'hf0);
    // Triple-function port ignores the peripheral's own route
    wr(MODE_BASE + 8'h07, 8'hff);
    wr(SEL_BASE + 8'h07, 8'hf0);
    cyc(2);
    #1 chk(padOut[7], 8'h21);
    $display("peripheral routing done");
    // Input stays blocked until the gate bit is set
    rd(DATA_BASE + 8'h0a, d);
    chk(d, 8'h00);
    chk(periphIn[10], 8'h00);
    wr(INCTL_ADDR, 8'h01);
    cyc(8);
    rd(DATA_BASE + 8'h0a, d);
    chk(d, 8'h5a);
    chk(periphIn[10], 8'h5a);
    // Sense positions follow break and strap pins; mode stays frozen
    rd(DATA_BASE + 8'h09, d);
    chk(d, 8'h01);
    systemBreakInputN <= 1'b0;
    modeStrapA <= 1'b1;
    cyc(8);
    rd(DATA_BASE + 8'h09, d);
    chk(d, 8'h02);
    rd(STATUS_ADDR, d);
    chk(d, 8'h04);
    $display("input path done");
    // Missing port and unmapped address hold nothing
    wr(DATA_BASE + 8'h05, 8'hff);
    rd(DATA_BASE + 8'h05, d);
    chk(d, 8'h00);
    rd(8'h90, d);
    chk(d, 8'h00);
    rd(MODE_BASE + 8'h0a, d);
    chk(d, 8'hf0);
    $display("register map done");
    report_and_stop();
  end
endmodule // test_port_pin_function_select
